// >>> hw/ofd_pkg.sv
package ofd_pkg;

    // Fixed opcodes
    localparam logic [7:0] OP_SET_DIR = 8'hFD;
    localparam logic [7:0] OP_MASK_INT = 8'hFA;
    localparam logic [7:0] OP_UNMASK_INT = 8'hFB;
    localparam logic [7:0] OP_STOP = 8'hF4;
    localparam logic [7:0] OP_WAIT = 8'h9B;
    localparam logic [7:0] OP_LOCK = 8'hF0;
    localparam logic [6:0] OP_REP_HI = 7'h79;
    localparam logic [4:0] OP_HANDOFF_HI = 5'h1B;

    // Segment override prefix: 001 ss 110
    localparam logic [2:0] SEG_PFX_HI = 3'h1;
    localparam logic [2:0] SEG_PFX_LO = 3'h6;

    // Opcode groups by upper bits
    localparam logic [3:0] OP_BRANCH_HI = 4'h7;
    localparam logic [5:0] OP_IMM_GRP_HI = 6'h20;
    localparam logic [5:0] OP_MOVE_HI = 6'h22;
    localparam logic [5:0] OP_SHIFT_HI = 6'h34;
    localparam logic [1:0] OP_ALU_HI = 2'h0;

    // Opcode bit positions
    localparam int OPB_WIDTH = 0;
    localparam int OPB_DIR = 1;
    localparam int OPB_SIGN = 1;
    localparam int OPB_COUNT = 1;
    localparam int OPB_ALU_ACC = 2;

    // Operand-form byte fields
    localparam logic [1:0] MOD_NO_DISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP16 = 2'h2;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    localparam logic [2:0] REG_ACC = 3'h0;
    localparam logic [1:0] SEG_EXTRA = 2'h0;

    // Reset and fixed values
    localparam logic [7:0] SHIFT_ONE = 8'h01;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;

    typedef enum logic [2:0] {
        S_OPC,
        S_MODRM,
        S_DISP_LO,
        S_DISP_HI,
        S_IMM_LO,
        S_IMM_HI,
        S_EXEC
    } ofd_state_e;

endpackage

// >>> hw/ofd_decoder.sv
`timescale 1ns/1ps

// How it works
// RULE_01: Decode set-direction, mask and unmask interrupt opcodes.
// RULE_02: Decode stop and wait opcodes, no operands.
// RULE_03: Escape pattern hands off; operand byte follows.
// RULE_04: Lock prefix holds bus lock over next instruction.
// RULE_05: Above/below unsigned, greater/less signed branch tests.
// RULE_06: Direction bit set: register field is destination.
// RULE_07: Width bit picks word or byte operation.
// RULE_08: Sign and width set: one immediate, sign-extended.
// RULE_09: Count bit clear: shift one, else count register.
// RULE_10: Repeat low bit compared with zero flag.
// RULE_11: Segment prefix redirects next memory operand.
// RULE_12: Form 11 makes operand-select a register.
// RULE_13: Form 00 means no displacement, except direct.
// RULE_14: Form 01 fetches one byte, sign-extended.
// RULE_15: Form 10 fetches two bytes, low first.
// RULE_16: Register 000 is accumulator; segment 00 extra.
// RULE_17: Memory address is base plus index plus displacement.
// RULE_18: Form 00 with select 110 is direct address.
module ofd_decoder
    import ofd_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    output logic BYTE_READY,
    input wire logic ZERO_FLAG,
    input wire logic CARRY_FLAG,
    input wire logic SIGN_FLAG,
    input wire logic OVERFLOW_FLAG,
    input wire logic PARITY_FLAG,
    input wire logic [7:0] COUNT_LOW,
    input wire logic [15:0] BASE_WORD_POINTER,
    input wire logic [15:0] FRAME_POINTER,
    input wire logic [15:0] SOURCE_INDEX,
    input wire logic [15:0] TARGET_POINTER,
    output logic INSN_DONE,
    output logic [7:0] OPCODE,
    output logic SET_STRING_DIRECTION_OP,
    output logic MASK_INTERRUPTS_OP,
    output logic UNMASK_INTERRUPTS_OP,
    output logic PROCESSOR_STOP_OP,
    output logic TEST_WAIT_OP,
    output logic COPROCESSOR_HANDOFF_OP,
    output logic BUS_LOCKED,
    output logic BRANCH_TAKEN,
    output logic REG_IS_DEST,
    output logic WORD_OP,
    output logic [2:0] REG_SEL,
    output logic REG_WORD_ACCUMULATOR,
    output logic REG_BYTE_ACCUMULATOR,
    output logic RM_IS_REG,
    output logic [2:0] RM_SEL,
    output logic [15:0] DISP,
    output logic [15:0] IMM,
    output logic [7:0] SHIFT_COUNT,
    output logic [15:0] OPERAND_LOCATION,
    output logic SEG_OVERRIDE,
    output logic [1:0] SEG_SEL,
    output logic EXTRA_SEGMENT_REG,
    output logic REP_ACTIVE,
    output logic REP_CONTINUE
);

    function automatic logic has_modrm(input logic [7:0] op);
        has_modrm = (op[7:3] == OP_HANDOFF_HI) || (op[7:2] == OP_IMM_GRP_HI)
            || (op[7:2] == OP_MOVE_HI) || (op[7:2] == OP_SHIFT_HI)
            || (op[7:6] == OP_ALU_HI && !op[OPB_ALU_ACC] && !op[5]);
    endfunction

    function automatic logic [1:0] imm_bytes(input logic [7:0] op);
        if (op[7:4] == OP_BRANCH_HI) begin
            imm_bytes = 2'd1;
        end else if (op[7:2] == OP_IMM_GRP_HI) begin
            imm_bytes = (op[OPB_SIGN] && op[OPB_WIDTH]) ? 2'd1 : // [RULE_08]
                (op[OPB_WIDTH] ? 2'd2 : 2'd1);
        end else if (op[7:6] == OP_ALU_HI && op[OPB_ALU_ACC] && !op[1] && !op[5]) begin
            imm_bytes = op[OPB_WIDTH] ? 2'd2 : 2'd1;
        end else begin
            imm_bytes = 2'd0;
        end
    endfunction

    function automatic logic imm_sext(input logic [7:0] op);
        imm_sext = (op[7:4] == OP_BRANCH_HI) || ((op[7:2] == OP_IMM_GRP_HI)
            && op[OPB_SIGN] && op[OPB_WIDTH]); // [RULE_08]
    endfunction

    function automatic logic [1:0] disp_bytes(input logic [7:0] mrm);
        unique case (mrm[7:6])
            MOD_NO_DISP: disp_bytes = (mrm[2:0] == RM_DIRECT) ? 2'd2 : 2'd0; // [RULE_13] [RULE_18]
            MOD_DISP8: disp_bytes = 2'd1; // [RULE_14]
            MOD_DISP16: disp_bytes = 2'd2; // [RULE_15]
            MOD_REG: disp_bytes = 2'd0; // [RULE_12]
        endcase
    endfunction

    function automatic logic cond_met(input logic [3:0] cc, input logic o, input logic c,
        input logic z, input logic s, input logic p);
        logic r;
        r = 1'b0;
        unique case (cc[3:1])
            3'd0: r = o;
            3'd1: r = c; // [RULE_05]
            3'd2: r = z;
            3'd3: r = c | z; // [RULE_05]
            3'd4: r = s;
            3'd5: r = p;
            3'd6: r = s ^ o; // [RULE_05]
            3'd7: r = (s ^ o) | z; // [RULE_05]
        endcase
        cond_met = r ^ cc[0];
    endfunction

    logic rst_s1_q;
    logic rst_n_q;
    ofd_state_e state_q;
    ofd_state_e state_d;
    logic [7:0] opcode_q;
    logic [7:0] modrm_q;
    logic [15:0] disp_q;
    logic [15:0] imm_q;
    logic lock_q;
    logic rep_q;
    logic rep_z_q;
    logic seg_q;
    logic [1:0] seg_sel_q;
    logic done_q;
    logic rep_cont_q;
    logic [7:0] out_op_q;
    logic [4:0] out_ctl_q;
    logic out_hand_q;
    logic out_br_q;
    logic out_dir_q;
    logic out_word_q;
    logic out_rmreg_q;
    logic out_seg_q;
    logic [1:0] out_segsel_q;
    logic out_rep_q;
    logic [15:0] out_disp_q;
    logic [15:0] out_imm_q;
    logic [7:0] out_shift_q;
    logic [15:0] out_loc_q;
    logic [7:0] out_mrm_q;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    wire take = CLK_EN && BYTE_VALID && state_q != S_EXEC;
    wire is_lock = BYTE_DATA == OP_LOCK;
    wire is_rep = BYTE_DATA[7:1] == OP_REP_HI;
    wire is_seg = BYTE_DATA[7:5] == SEG_PFX_HI && BYTE_DATA[2:0] == SEG_PFX_LO;
    wire is_prefix = is_lock || is_rep || is_seg;
    wire [1:0] imm_n_op = imm_bytes(opcode_q);
    wire [1:0] disp_n = disp_bytes(modrm_q);
    wire [1:0] disp_n_in = disp_bytes(BYTE_DATA);
    wire [15:0] byte_sext = {{8{BYTE_DATA[7]}}, BYTE_DATA};
    wire [15:0] byte_zext = {ZERO8, BYTE_DATA};
    wire [1:0] mode = modrm_q[7:6];
    wire [2:0] rm = modrm_q[2:0];
    wire direct = mode == MOD_NO_DISP && rm == RM_DIRECT; // [RULE_18]
    wire [15:0] base_sel = rm[1] ? FRAME_POINTER : BASE_WORD_POINTER;
    wire [15:0] idx_sel = rm[0] ? TARGET_POINTER : SOURCE_INDEX;
    wire [15:0] pair_sum = base_sel + idx_sel;
    wire [15:0] single_sel = (rm == 3'h4) ? SOURCE_INDEX :
        (rm == 3'h5) ? TARGET_POINTER : (rm == 3'h6) ? FRAME_POINTER : BASE_WORD_POINTER;
    wire [15:0] reg_sum = rm[2] ? single_sel : pair_sum;
    wire [15:0] loc = direct ? disp_q : reg_sum + disp_q; // [RULE_17] [RULE_18]
    wire is_branch = opcode_q[7:4] == OP_BRANCH_HI;
    wire is_shift = opcode_q[7:2] == OP_SHIFT_HI;
    wire is_alu_rm = opcode_q[7:6] == OP_ALU_HI && !opcode_q[OPB_ALU_ACC] && !opcode_q[5];
    wire has_dir = is_alu_rm || opcode_q[7:2] == OP_MOVE_HI;
    wire has_w = has_modrm(opcode_q) && opcode_q[7:3] != OP_HANDOFF_HI || imm_n_op != 2'd0
        && !is_branch;
    wire after_mrm_imm = imm_n_op != 2'd0;
    wire rep_now = (state_q == S_EXEC) ? rep_q : out_rep_q;

    assign BYTE_READY = state_q != S_EXEC;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_OPC: begin
                if (!is_prefix) begin // [RULE_04] [RULE_11]
                    if (has_modrm(BYTE_DATA)) begin // [RULE_03]
                        state_d = S_MODRM;
                    end else if (imm_bytes(BYTE_DATA) != 2'd0) begin
                        state_d = S_IMM_LO;
                    end else begin
                        state_d = S_EXEC; // [RULE_01] [RULE_02]
                    end
                end
            end
            S_MODRM: begin
                if (disp_n_in != 2'd0) begin
                    state_d = S_DISP_LO;
                end else begin
                    state_d = after_mrm_imm ? S_IMM_LO : S_EXEC; // [RULE_13]
                end
            end
            S_DISP_LO: begin
                if (disp_n == 2'd2) begin
                    state_d = S_DISP_HI; // [RULE_15]
                end else begin
                    state_d = after_mrm_imm ? S_IMM_LO : S_EXEC;
                end
            end
            S_DISP_HI: state_d = after_mrm_imm ? S_IMM_LO : S_EXEC;
            S_IMM_LO: state_d = (imm_n_op == 2'd2) ? S_IMM_HI : S_EXEC;
            S_IMM_HI: state_d = S_EXEC;
            S_EXEC: state_d = S_OPC;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= S_OPC;
        end else if (take || (CLK_EN && state_q == S_EXEC)) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            opcode_q <= ZERO8;
            modrm_q <= ZERO8;
            disp_q <= ZERO16;
            imm_q <= ZERO16;
        end else if (take) begin
            unique case (state_q)
                S_OPC: begin
                    if (!is_prefix) begin
                        opcode_q <= BYTE_DATA;
                        modrm_q <= ZERO8;
                        disp_q <= ZERO16; // [RULE_13]
                        imm_q <= ZERO16;
                    end
                end
                S_MODRM: modrm_q <= BYTE_DATA;
                S_DISP_LO: disp_q <= byte_sext; // [RULE_14]
                S_DISP_HI: disp_q <= {BYTE_DATA, disp_q[7:0]}; // [RULE_15]
                S_IMM_LO: imm_q <= imm_sext(opcode_q) ? byte_sext : byte_zext; // [RULE_08]
                S_IMM_HI: imm_q <= {BYTE_DATA, imm_q[7:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_q <= 1'b0;
            rep_q <= 1'b0;
            rep_z_q <= 1'b0;
            seg_q <= 1'b0;
            seg_sel_q <= SEG_EXTRA;
        end else if (take && state_q == S_OPC && is_prefix) begin
            lock_q <= lock_q | is_lock; // [RULE_04]
            rep_q <= rep_q | is_rep;
            rep_z_q <= is_rep ? BYTE_DATA[0] : rep_z_q; // [RULE_10]
            seg_q <= seg_q | is_seg; // [RULE_11]
            seg_sel_q <= is_seg ? BYTE_DATA[4:3] : seg_sel_q;
        end else if (CLK_EN && state_q == S_EXEC) begin
            lock_q <= 1'b0;
            rep_q <= 1'b0;
            seg_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_q <= 1'b0;
            rep_cont_q <= 1'b0;
        end else if (CLK_EN) begin
            done_q <= state_q == S_EXEC;
            rep_cont_q <= rep_now && (ZERO_FLAG == rep_z_q); // [RULE_10]
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_op_q <= ZERO8;
            out_ctl_q <= 5'h00;
            out_hand_q <= 1'b0;
            out_br_q <= 1'b0;
            out_dir_q <= 1'b0;
            out_word_q <= 1'b0;
            out_rmreg_q <= 1'b0;
            out_seg_q <= 1'b0;
            out_segsel_q <= SEG_EXTRA;
            out_rep_q <= 1'b0;
            out_disp_q <= ZERO16;
            out_imm_q <= ZERO16;
            out_shift_q <= ZERO8;
            out_loc_q <= ZERO16;
            out_mrm_q <= ZERO8;
        end else if (CLK_EN && state_q == S_EXEC) begin
            out_op_q <= opcode_q;
            out_ctl_q <= {opcode_q == OP_SET_DIR, opcode_q == OP_MASK_INT,
                opcode_q == OP_UNMASK_INT, opcode_q == OP_STOP, opcode_q == OP_WAIT}; // [RULE_01] [RULE_02]
            out_hand_q <= opcode_q[7:3] == OP_HANDOFF_HI; // [RULE_03]
            out_br_q <= is_branch && cond_met(opcode_q[3:0], OVERFLOW_FLAG, CARRY_FLAG,
                ZERO_FLAG, SIGN_FLAG, PARITY_FLAG); // [RULE_05]
            out_dir_q <= has_dir && opcode_q[OPB_DIR]; // [RULE_06]
            out_word_q <= has_w && opcode_q[OPB_WIDTH]; // [RULE_07]
            out_rmreg_q <= has_modrm(opcode_q) && mode == MOD_REG; // [RULE_12]
            out_seg_q <= seg_q; // [RULE_11]
            out_segsel_q <= seg_sel_q;
            out_rep_q <= rep_q;
            out_disp_q <= disp_q;
            out_imm_q <= imm_q;
            out_shift_q <= !is_shift ? ZERO8 :
                (opcode_q[OPB_COUNT] ? COUNT_LOW : SHIFT_ONE); // [RULE_09]
            out_loc_q <= loc;
            out_mrm_q <= modrm_q;
        end
    end

    assign INSN_DONE = done_q;
    assign OPCODE = out_op_q;
    assign SET_STRING_DIRECTION_OP = out_ctl_q[4];
    assign MASK_INTERRUPTS_OP = out_ctl_q[3];
    assign UNMASK_INTERRUPTS_OP = out_ctl_q[2];
    assign PROCESSOR_STOP_OP = out_ctl_q[1];
    assign TEST_WAIT_OP = out_ctl_q[0];
    assign COPROCESSOR_HANDOFF_OP = out_hand_q;
    assign BUS_LOCKED = lock_q;
    assign BRANCH_TAKEN = out_br_q;
    assign REG_IS_DEST = out_dir_q;
    assign WORD_OP = out_word_q;
    assign REG_SEL = out_mrm_q[5:3];
    assign REG_WORD_ACCUMULATOR = out_mrm_q[5:3] == REG_ACC && out_word_q; // [RULE_16]
    assign REG_BYTE_ACCUMULATOR = out_mrm_q[5:3] == REG_ACC && !out_word_q; // [RULE_16]
    assign RM_IS_REG = out_rmreg_q;
    assign RM_SEL = out_mrm_q[2:0];
    assign DISP = out_disp_q;
    assign IMM = out_imm_q;
    assign SHIFT_COUNT = out_shift_q;
    assign OPERAND_LOCATION = out_loc_q;
    assign SEG_OVERRIDE = out_seg_q;
    assign SEG_SEL = out_segsel_q;
    assign EXTRA_SEGMENT_REG = out_seg_q && out_segsel_q == SEG_EXTRA; // [RULE_16]
    assign REP_ACTIVE = out_rep_q;
    assign REP_CONTINUE = rep_cont_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n_q || !CLK_EN);

    sequence s_opc(logic [7:0] b);
        take && state_q == S_OPC && BYTE_DATA == b;
    endsequence
    sequence s_done;
        ##1 state_q == S_EXEC ##1 INSN_DONE;
    endsequence

    property p_set_dir;
        s_opc(OP_SET_DIR) |-> s_done ##0 SET_STRING_DIRECTION_OP;
    endproperty
    a_set_dir: assert property (p_set_dir) else $error("set direction not decoded"); // [RULE_01]
    property p_stop;
        s_opc(OP_STOP) |-> s_done ##0 PROCESSOR_STOP_OP && !TEST_WAIT_OP;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not decoded"); // [RULE_02]
    property p_handoff;
        take && state_q == S_OPC && BYTE_DATA[7:3] == OP_HANDOFF_HI |=> state_q == S_MODRM;
    endproperty
    a_handoff: assert property (p_handoff) else $error("handoff lacks operand byte"); // [RULE_03]
    property p_lock;
        s_opc(OP_LOCK) |=> BUS_LOCKED && state_q == S_OPC && !INSN_DONE;
    endproperty
    a_lock: assert property (p_lock) else $error("lock prefix not held"); // [RULE_04]
    sequence s_imm_sx;
        s_opc(8'h83) ##1 take && BYTE_DATA[7:6] == MOD_REG ##1 take;
    endsequence
    property p_imm_sx;
        s_imm_sx |=> imm_q == {{8{$past(BYTE_DATA[7])}}, $past(BYTE_DATA)} ##1 INSN_DONE;
    endproperty
    a_imm_sx: assert property (p_imm_sx) else $error("immediate not sign extended"); // [RULE_08]
    sequence s_rep_match;
        s_opc(8'hF3) ##1 s_opc(8'hA6) ##1 ZERO_FLAG;
    endsequence
    property p_rep;
        s_rep_match |=> REP_CONTINUE && REP_ACTIVE && INSN_DONE;
    endproperty
    a_rep: assert property (p_rep) else $error("repeat test wrong"); // [RULE_10]
    property p_reg_form;
        take && state_q == S_MODRM && BYTE_DATA[7:6] == MOD_REG && imm_n_op == 2'd0
            |=> state_q == S_EXEC ##1 INSN_DONE && RM_IS_REG;
    endproperty
    a_reg_form: assert property (p_reg_form) else $error("register form wrong"); // [RULE_12]
    property p_disp8;
        take && state_q == S_DISP_LO && disp_n == 2'd1
            |=> disp_q == {{8{$past(BYTE_DATA[7])}}, $past(BYTE_DATA)};
    endproperty
    a_disp8: assert property (p_disp8) else $error("short displacement wrong"); // [RULE_14]
    property p_disp16;
        take && state_q == S_DISP_HI |=> disp_q[15:8] == $past(BYTE_DATA)
            && disp_q[7:0] == $past(disp_q[7:0]);
    endproperty
    a_disp16: assert property (p_disp16) else $error("long displacement wrong"); // [RULE_15]

endmodule

// >>> bench/ofd_byte_source.sv
`timescale 1ns/1ps

// Instruction memory stand-in: offers queued bytes in order
module ofd_byte_source (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic ready,
    input wire logic slow,
    output logic valid,
    output logic [7:0] data
);
    logic [7:0] q[$];

    function automatic void push(input logic [7:0] b);
        q.push_back(b);
    endfunction

    // Byte held until taken; idle lines invert their previous value every cycle
    always @(posedge clk or negedge rst_n) begin
        logic took;
        if (!rst_n) begin
            valid <= 1'b0;
            data <= 8'hA5;
        end else begin
            took = valid && ready && en;
            if (took) begin
                void'(q.pop_front());
            end
            if (q.size() != 0 && !(slow && took)) begin
                valid <= 1'b1;
                data <= q[0];
            end else begin
                valid <= 1'b0;
                data <= ~data;
            end
        end
    end
endmodule

// >>> bench/ofd_decoder_bench.sv
`timescale 1ns/1ps

module ofd_decoder_bench;
    import ofd_pkg::*;
    typedef struct {
        logic [47:0] b;
        int n;
        logic [5:0] ops;
        logic [5:0] misc;
        logic [3:0] m;
        logic [15:0] disp;
        logic [15:0] imm;
        logic [15:0] loc;
        logic [7:0] sc;
        logic [4:0] fl;
    } ofd_row_s;
    ofd_row_s rows[$];
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic slow = 1'b0;
    logic zflag = 1'b0;
    logic cf = 1'b0;
    logic sf = 1'b0;
    logic ovf = 1'b0;
    logic pf = 1'b0;
    logic [7:0] cnt = 8'h07;
    logic [15:0] bwp = 16'h1000;
    logic [15:0] fp = 16'h2000;
    logic [15:0] si = 16'h0300;
    logic [15:0] tp = 16'h0040;
    logic saw_lock = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    wire valid, ready, done, lock, br, dest, word, wacc, bacc, rmreg, sov, extra, repa, repc;
    wire [7:0] data, opc, sc;
    wire [5:0] ops;
    wire [15:0] disp, imm, loc;
    wire [1:0] ssel;
    wire [2:0] rsel, msel;

    always #2.5 clk = ~clk;

    ofd_byte_source src_u (.clk(clk), .rst_n(rst_n), .en(en), .ready(ready), .slow(slow),
        .valid(valid), .data(data));

    ofd_decoder dut_u (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(en), .BYTE_VALID(valid),
        .BYTE_DATA(data), .BYTE_READY(ready), .ZERO_FLAG(zflag), .CARRY_FLAG(cf),
        .SIGN_FLAG(sf), .OVERFLOW_FLAG(ovf), .PARITY_FLAG(pf), .COUNT_LOW(cnt),
        .BASE_WORD_POINTER(bwp), .FRAME_POINTER(fp), .SOURCE_INDEX(si),
        .TARGET_POINTER(tp), .INSN_DONE(done), .OPCODE(opc),
        .SET_STRING_DIRECTION_OP(ops[5]), .MASK_INTERRUPTS_OP(ops[4]),
        .UNMASK_INTERRUPTS_OP(ops[3]), .PROCESSOR_STOP_OP(ops[2]), .TEST_WAIT_OP(ops[1]),
        .COPROCESSOR_HANDOFF_OP(ops[0]), .BUS_LOCKED(lock), .BRANCH_TAKEN(br),
        .REG_IS_DEST(dest), .WORD_OP(word), .REG_SEL(rsel), .REG_WORD_ACCUMULATOR(wacc),
        .REG_BYTE_ACCUMULATOR(bacc), .RM_IS_REG(rmreg), .RM_SEL(msel), .DISP(disp), .IMM(imm),
        .SHIFT_COUNT(sc), .OPERAND_LOCATION(loc), .SEG_OVERRIDE(sov), .SEG_SEL(ssel),
        .EXTRA_SEGMENT_REG(extra), .REP_ACTIVE(repa), .REP_CONTINUE(repc));

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic void add(logic [47:0] b, int n, logic [5:0] ops, logic [5:0] misc,
        logic [3:0] m = 0, logic [15:0] disp = 0, logic [15:0] imm = 0,
        logic [15:0] loc = 0, logic [7:0] sc = 0, logic [4:0] fl = 0);
        rows.push_back('{b, n, ops, misc, m, disp, imm, loc, sc, fl});
    endfunction

    // Sets flags, queues the bytes, then waits for the done pulse
    task automatic run(input logic [47:0] b, input int n, input logic [4:0] fl,
        input logic sl);
        int k;
        @(posedge clk);
        {zflag, cf, sf, ovf, pf} <= fl;
        slow <= sl;
        #1;
        for (k = 0; k < n; k++) begin
            src_u.push(b[8 * (n - 1 - k) +: 8]);
        end
        saw_lock = 1'b0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (lock === 1'b1) begin
                saw_lock = 1'b1;
            end
            if (done === 1'b1) begin
                break;
            end
        end
        if (k == 40) begin
            fail_count++;
            $display("BAD t=%0t no done", $time);
            results();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk(16'(ready), 16'h1, "ready in reset");
        chk(16'(opc), 16'h0, "opcode in reset");
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        add('hFD, 1, 6'h20, 0);
        add('hFA, 1, 6'h10, 0);
        add('hFB, 1, 6'h08, 0);
        add('hF4, 1, 6'h04, 0);
        add('h9B, 1, 6'h02, 0);
        add('hD9C0, 2, 6'h01, 6'b001000);
        add('h83C0FB, 3, 0, 6'b001100, 4'h2, 0, 16'hFFFB);
        add('h81C03412, 4, 0, 6'b001100, 4'h2, 0, 16'h1234);
        add('h80C0FB, 3, 0, 6'b001000, 4'h2, 0, 16'h00FB);
        add('h8B4610, 3, 0, 6'b010100, 4'h5, 16'h0010, 0, 16'h2010);
        add('h8946F0, 3, 0, 6'b000100, 4'h5, 16'hFFF0, 0, 16'h1FF0);
        add('h8A873412, 4, 0, 6'b010000, 4'h5, 16'h1234, 0, 16'h2234);
        add('h8B00, 2, 0, 6'b010100, 4'h5, 0, 0, 16'h1300);
        add('h8B067856, 4, 0, 6'b010100, 4'h1, 0, 0, 16'h5678);
        add('h8BC0, 2, 0, 6'b011110, 4'h8);
        add('h8AC0, 2, 0, 6'b011001, 4'h8);
        add('hD1E0, 2, 0, 6'b001100, 0, 0, 0, 0, 8'h01);
        add('hD3E0, 2, 0, 6'b001100, 0, 0, 0, 0, 8'h07);
        add('h7205, 2, 0, 6'b100000, 4'h2, 0, 16'h0005, 0, 0, 5'b01000);
        add('h7CFB, 2, 0, 6'b100000, 4'h2, 0, 16'hFFFB, 0, 0, 5'b00100);
        add('h7CFB, 2, 0, 0, 4'h2, 0, 16'hFFFB, 0, 0, 5'b00110);
        add('h7705, 2, 0, 6'b100000);
        add('h7705, 2, 0, 0, 0, 0, 0, 0, 0, 5'b10000);
        foreach (rows[i]) begin
            run(rows[i].b, rows[i].n, rows[i].fl, i[0]);
            chk(16'(opc), 16'(rows[i].b[8 * (rows[i].n - 1) +: 8]), "opcode");
            chk(16'(ops), 16'(rows[i].ops), "op flags");
            chk(16'({br, dest, rmreg, word}), 16'(rows[i].misc[5:2]), "fields");
            if (rows[i].m[3]) begin
                chk(16'({wacc, bacc}), 16'(rows[i].misc[1:0]), "acc");
            end
            if (rows[i].m[2]) begin
                chk(disp, rows[i].disp, "disp");
            end
            if (rows[i].m[1]) begin
                chk(imm, rows[i].imm, "imm");
            end
            if (rows[i].m[0]) begin
                chk(loc, rows[i].loc, "location");
            end
            chk(16'(sc), 16'(rows[i].sc), "shift count");
            chk(16'(saw_lock), 16'h0, "lock");
            $display("row %0d finished", i);
        end
        run('hF0FD, 2, 0, 1'b1);
        chk(16'(saw_lock), 16'h1, "lock seen");
        chk(16'(lock), 16'h0, "lock dropped");
        chk(16'(ops), 16'h20, "locked op");
        $display("lock test finished");
        run('hF3A6, 2, 5'b10000, 1'b0);
        chk(16'({repa, repc}), 16'h3, "repeat match");
        run('hF2A6, 2, 5'b10000, 1'b1);
        chk(16'({repa, repc}), 16'h2, "repeat mismatch");
        $display("repeat test finished");
        run('h268B00, 3, 0, 1'b0);
        chk(16'({sov, ssel, extra}), 16'h9, "extra seg");
        chk(loc, 16'h1300, "seg location");
        run('h3E8B00, 3, 0, 1'b1);
        chk(16'({sov, ssel, extra}), 16'hE, "data seg");
        run('h8B00, 2, 0, 1'b0);
        chk(16'(sov), 16'h0, "prefix cleared");
        $display("segment test finished");
        run('h8BD7, 2, 0, 1'b0);
        chk(16'({rsel, msel, wacc, bacc}), 16'h005C, "reg fields");
        $display("field test finished");
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(opc), 16'h0, "opcode reset");
        chk(16'(ready), 16'h1, "ready reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        run('hFB, 1, 0, 1'b0);
        chk(16'(ops), 16'h08, "after reset");
        $display("reset test finished");
        @(posedge clk);
        en <= 1'b0;
        #1;
        src_u.push(8'hFA);
        repeat (4) @(posedge clk);
        #1;
        chk(16'({done, opc}), 16'h00FB, "frozen");
        @(posedge clk);
        en <= 1'b1;
        run(0, 0, 0, 1'b0);
        chk(16'(ops), 16'h10, "after freeze");
        $display("freeze test finished");
        results();
    end
endmodule
